// ==== hw/acc_conv_ctrl.sv ====
// a/d conversion control: timing, triggers, compare window, axi4-lite regs
// Notes on behaviour
// - conversion lasts mode-dependent cycles: 1728/2112/2432/7360 at div32, scaled.
// - trigger-mode high bit zero means software trigger, low bit ignored.
// - modes 1,0: each hardware trigger starts conversion immediately.
// - modes 1,1: hardware trigger, then stabilization wait, then conversion.
// - source 00 selects timer channel 1 interrupt; 01 and 10 prohibited.
// - source 11 selects the interval timer interrupt.
// - positive reference: supply, external pin, internal 1.45 V; 11 prohibited.
// - negative reference: analog ground at 0, external pin at 1.
// - sense 0: interrupt when lower <= result <= upper.
// - sense 1: interrupt when result below lower or above upper.
// - low_power_wake_state enable lets hardware triggers convert in low_power_wake_state state.
// - resolution bit: 0 gives 12-bit result, 1 gives 8-bit.
// - 8-bit read-write upper limit register, reset all ones.
// - 8-bit read-write lower limit register, reset zero.
// - run bit reads busy in software mode and wait mode.
// - comparator enable powers the comparator; no conversion without it.
// - channel mode bit: 0 select mode, 1 scan mode.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl #(
  parameter int CYC_NORMAL1 = acc_pkg::CONV_CYC_NORMAL1,
  parameter int CYC_NORMAL2 = acc_pkg::CONV_CYC_NORMAL2,
  parameter int CYC_LOWV1   = acc_pkg::CONV_CYC_LOWV1,
  parameter int CYC_LOWV2   = acc_pkg::CONV_CYC_LOWV2
) (
  input  wire logic                      CORE_CLK_IN,
  input  wire logic                      RST_N_IN,
  input  wire logic [acc_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic                      S_AXI_AWVALID_IN,
  output logic                           S_AXI_AWREADY_OUT,
  input  wire logic [31:0]               S_AXI_WDATA_IN,
  input  wire logic [3:0]                S_AXI_WSTRB_IN,
  input  wire logic                      S_AXI_WVALID_IN,
  output logic                           S_AXI_WREADY_OUT,
  output logic [1:0]                     S_AXI_BRESP_OUT,
  output logic                           S_AXI_BVALID_OUT,
  input  wire logic                      S_AXI_BREADY_IN,
  input  wire logic [acc_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic                      S_AXI_ARVALID_IN,
  output logic                           S_AXI_ARREADY_OUT,
  output logic [31:0]                    S_AXI_RDATA_OUT,
  output logic [1:0]                     S_AXI_RRESP_OUT,
  output logic                           S_AXI_RVALID_OUT,
  input  wire logic                      S_AXI_RREADY_IN,
  input  wire logic                      TIMER_CH1_IRQ_IN,
  input  wire logic                      INTERVAL_TIMER_IRQ_IN,
  input  wire logic                      LOW_POWER_WAKE_STATE_IN,
  input  wire logic [11:0]               ANALOG_SAMPLE_IN,
  output logic                           COMPARATOR_ENABLE_OUT,
  output logic                           CONVERTING_OUT,
  output logic [1:0]                     POS_REF_SEL_OUT,
  output logic                           NEG_REF_SEL_OUT,
  output logic                           CHANNEL_MODE_OUT,
  output logic                           CONVERSION_END_IRQ_OUT,
  output logic                           IRQ_OUT
);
  localparam logic [12:0] CYC_STAB = 13'(acc_pkg::STAB_CYC);

  // register file
  logic [7:0]  mode_ctrl_r;
  logic [7:0]  trig_cfg_r;
  logic [7:0]  ref_cfg_r;
  logic [7:0]  upper_limit_r;
  logic [7:0]  lower_limit_r;
  logic [11:0] result_r;
  logic [acc_pkg::IRQ_BITS-1:0] irq_status_r;
  logic [acc_pkg::IRQ_BITS-1:0] irq_mask_r;
  logic        run_en_r;

  // bus slave state
  logic [acc_pkg::ADDR_W-1:0] aw_addr_r;
  logic        aw_held_r;
  logic [7:0]  w_data_r;
  logic        w_lane0_r;
  logic        w_held_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // conversion engine
  acc_pkg::acc_state_t state_r;
  acc_pkg::acc_state_t state_nxt;
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic        end_pulse_r;
  logic [11:0] samp_s1_r;
  logic [11:0] samp_s2_r;
  logic [11:0] samp_s3_r;
  logic [11:0] samp_stable_r;
  logic        comp_en_r;
  logic        conv_r;
  logic [1:0]  posref_r;
  logic        negref_r;
  logic        chan_r;
  logic        irq_r;

  // ---------------- field decode ----------------
  wire       f_comp_en  = mode_ctrl_r[acc_pkg::MC_CMP_EN];
  wire [2:0] f_div      = mode_ctrl_r[acc_pkg::MC_DIV_LSB +: 3];
  wire [1:0] f_vmode    = mode_ctrl_r[acc_pkg::MC_VM_LSB +: 2];
  wire       f_tm_hi    = trig_cfg_r[acc_pkg::TC_MODE_HI];
  wire       f_tm_lo    = trig_cfg_r[acc_pkg::TC_MODE_LO];
  wire       f_oneshot  = trig_cfg_r[acc_pkg::TC_ONESHOT];
  wire [1:0] f_src      = trig_cfg_r[acc_pkg::TC_SRC_LSB +: 2];
  wire [1:0] f_posref   = ref_cfg_r[acc_pkg::RC_POS_LSB +: 2];
  wire       f_sense    = ref_cfg_r[acc_pkg::RC_SENSE];
  wire       f_low_power_wake_state   = ref_cfg_r[acc_pkg::RC_LOW_POWER_WAKE_STATE];
  wire       f_res8     = ref_cfg_r[acc_pkg::RC_RES];

  wire sw_mode     = !f_tm_hi;
  wire hw_nowait   = f_tm_hi && !f_tm_lo;
  wire hw_wait     = f_tm_hi && f_tm_lo;

  // triggers come from timers on this clock, so no synchroniser
  wire src_timer   = (f_src == acc_pkg::SRC_TIMER_CH1) && TIMER_CH1_IRQ_IN;
  wire src_itv     = (f_src == acc_pkg::SRC_INTERVAL)
                     && INTERVAL_TIMER_IRQ_IN;
  wire hw_allowed  = !LOW_POWER_WAKE_STATE_IN || f_low_power_wake_state;
  wire hw_trig     = f_tm_hi && (src_timer || src_itv) && hw_allowed;

  // conversion length scaled by divider ratio
  function automatic logic [12:0] conv_len(input logic [1:0] vm,
                                           input logic [2:0] dv);
    logic [17:0] base;
    logic [5:0]  ratio;
    logic [17:0] prod;
    base = 18'd0;
    ratio = 6'd0;
    prod = 18'd0;
    unique case (vm)
      2'b00: base = 18'(CYC_NORMAL1);
      2'b01: base = 18'(CYC_NORMAL2);
      2'b10: base = 18'(CYC_LOWV1);
      2'b11: base = 18'(CYC_LOWV2);
    endcase
    unique case (dv)
      3'b000: ratio = 6'd32;
      3'b001: ratio = 6'd16;
      3'b010: ratio = 6'd8;
      3'b011: ratio = 6'd8;
      3'b100: ratio = 6'd4;
      3'b101: ratio = 6'd4;
      3'b110: ratio = 6'd2;
      3'b111: ratio = 6'd1;
    endcase
    prod = 18'((base * {12'h000, ratio}) / 18'(acc_pkg::BASE_DIV));
    conv_len = (prod == 18'd0) ? 13'd1 : prod[12:0];
  endfunction

  wire [12:0] conv_cycles = conv_len(f_vmode, f_div);

  // ---------------- compare window ----------------
  // 8-bit mode keeps the result in the top byte, so one compare fits both
  wire [11:0] res_val    = f_res8 ? {samp_stable_r[11:4], 4'h0}
                                  : samp_stable_r;
  wire [7:0]  cmp_val    = samp_stable_r[11:4];
  wire        in_window  = (lower_limit_r <= cmp_val)
                           && (cmp_val <= upper_limit_r);
  wire        out_window = (cmp_val < lower_limit_r)
                           || (upper_limit_r < cmp_val);
  wire        cmp_hit    = f_sense ? out_window : in_window;

  // ---------------- state machine ----------------
  wire conv_done  = (state_r == acc_pkg::ACC_CONV) && (cnt_r == 13'd1);
  wire stab_done  = (state_r == acc_pkg::ACC_STAB) && (cnt_r == 13'd1);
  wire can_run    = run_en_r && f_comp_en;
  wire wr_commit;
  wire wr_mode_ctrl;
  wire sw_run_wr  = wr_commit && wr_mode_ctrl;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r > 13'd1) ? cnt_r - 13'd1 : cnt_r;
    unique case (state_r)
      acc_pkg::ACC_IDLE: begin
        if (can_run && sw_mode) begin
          state_nxt = acc_pkg::ACC_CONV;
          cnt_nxt   = conv_cycles;
        end else if (can_run && hw_nowait && hw_trig) begin
          state_nxt = acc_pkg::ACC_CONV;
          cnt_nxt   = conv_cycles;
        end else if (can_run && hw_wait && hw_trig) begin
          state_nxt = acc_pkg::ACC_STAB;
          cnt_nxt   = CYC_STAB;
        end
      end
      acc_pkg::ACC_STAB: begin
        if (stab_done) begin
          state_nxt = acc_pkg::ACC_CONV;
          cnt_nxt   = conv_cycles;
        end
      end
      acc_pkg::ACC_CONV: begin
        if (conv_done) begin
          if (f_oneshot) begin
            state_nxt = acc_pkg::ACC_IDLE;
          end else begin
            cnt_nxt   = conv_cycles;
          end
        end
      end
    endcase
    if (!can_run) begin
      state_nxt = acc_pkg::ACC_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= acc_pkg::ACC_IDLE;
      cnt_r   <= 13'd0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // the analog sample arrives unsynchronised; accept only a settled code
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      samp_s1_r     <= 12'h000;
      samp_s2_r     <= 12'h000;
      samp_s3_r     <= 12'h000;
      samp_stable_r <= 12'h000;
    end else begin
      samp_s1_r <= ANALOG_SAMPLE_IN;
      samp_s2_r <= samp_s1_r;
      samp_s3_r <= samp_s2_r;
      if (samp_s2_r == samp_s3_r) begin
        samp_stable_r <= samp_s3_r;
      end
    end
  end

  // ---------------- bus decode ----------------
  localparam int ADDR_W_HI = acc_pkg::ADDR_W - 1;
  wire [19:0] w_idx = aw_held_r ? aw_addr_r[ADDR_W_HI:2]
                                : S_AXI_AWADDR_IN[ADDR_W_HI:2];
  wire [7:0]  w_byte  = w_held_r ? w_data_r : S_AXI_WDATA_IN[7:0];
  wire        w_lane0 = w_held_r ? w_lane0_r : S_AXI_WSTRB_IN[0];
  wire aw_have  = aw_held_r || S_AXI_AWVALID_IN;
  wire w_have   = w_held_r || S_AXI_WVALID_IN;
  assign wr_commit = aw_have && w_have && !bvalid_r;
  wire wr_en    = wr_commit && w_lane0;
  assign wr_mode_ctrl = (w_idx == acc_pkg::IDX_MODE_CTRL);
  wire wr_trig  = (w_idx == acc_pkg::IDX_TRIG_CFG);
  wire wr_ref   = (w_idx == acc_pkg::IDX_REF_CMP_CFG);
  wire wr_upper = (w_idx == acc_pkg::IDX_UPPER_LIMIT);
  wire wr_lower = (w_idx == acc_pkg::IDX_LOWER_LIMIT);
  wire wr_stat  = (w_idx == acc_pkg::IDX_IRQ_STATUS);
  wire wr_mask  = (w_idx == acc_pkg::IDX_IRQ_MASK);
  wire wr_ok    = wr_mode_ctrl || wr_trig || wr_ref || wr_upper
                  || wr_lower || wr_stat || wr_mask
                  || (w_idx == acc_pkg::IDX_RESULT);

  wire [19:0] r_idx = S_AXI_ARADDR_IN[ADDR_W_HI:2];
  wire        rd_go = S_AXI_ARVALID_IN && !rvalid_r;
  // run bit shows activity, except no-wait mode where it shows enable
  wire run_rd  = hw_nowait ? run_en_r
                           : (state_r != acc_pkg::ACC_IDLE);
  wire [7:0] mode_rd = {run_rd, mode_ctrl_r[6:0]};
  wire [31:0] rd_mux =
    (r_idx == acc_pkg::IDX_MODE_CTRL)   ? {24'h000000, mode_rd} :
    (r_idx == acc_pkg::IDX_TRIG_CFG)    ? {24'h000000, trig_cfg_r} :
    (r_idx == acc_pkg::IDX_REF_CMP_CFG) ? {24'h000000, ref_cfg_r} :
    (r_idx == acc_pkg::IDX_UPPER_LIMIT) ? {24'h000000, upper_limit_r} :
    (r_idx == acc_pkg::IDX_LOWER_LIMIT) ? {24'h000000, lower_limit_r} :
    (r_idx == acc_pkg::IDX_RESULT)      ? {20'h00000, result_r} :
    (r_idx == acc_pkg::IDX_IRQ_STATUS)  ? {30'h00000000, irq_status_r} :
    (r_idx == acc_pkg::IDX_IRQ_MASK)    ? {30'h00000000, irq_mask_r} :
                                          32'h00000000;
  wire rd_ok = (r_idx == acc_pkg::IDX_MODE_CTRL)
               || (r_idx == acc_pkg::IDX_TRIG_CFG)
               || (r_idx == acc_pkg::IDX_REF_CMP_CFG)
               || (r_idx == acc_pkg::IDX_UPPER_LIMIT)
               || (r_idx == acc_pkg::IDX_LOWER_LIMIT)
               || (r_idx == acc_pkg::IDX_RESULT)
               || (r_idx == acc_pkg::IDX_IRQ_STATUS)
               || (r_idx == acc_pkg::IDX_IRQ_MASK);

  // ---------------- axi4-lite handshakes ----------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= acc_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_IN && !aw_held_r && !wr_commit) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && !w_held_r && !wr_commit) begin
        w_held_r  <= 1'b1;
        w_data_r  <= S_AXI_WDATA_IN[7:0];
        w_lane0_r <= S_AXI_WSTRB_IN[0];
      end
      if (wr_commit) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY_IN) begin
        bvalid_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= acc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- registers ----------------
  wire [acc_pkg::IRQ_BITS-1:0] irq_set = {conv_done, conv_done && cmp_hit};
  wire [acc_pkg::IRQ_BITS-1:0] irq_clr =
    (wr_en && wr_stat) ? w_byte[acc_pkg::IRQ_BITS-1:0] : '0;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_ctrl_r   <= acc_pkg::RST_MODE_CTRL;
      trig_cfg_r    <= acc_pkg::RST_TRIG_CFG;
      ref_cfg_r     <= acc_pkg::RST_REF_CMP_CFG;
      upper_limit_r <= acc_pkg::RST_UPPER_LIMIT;
      lower_limit_r <= acc_pkg::RST_LOWER_LIMIT;
      irq_mask_r    <= '0;
    end else if (wr_en) begin
      if (wr_mode_ctrl) mode_ctrl_r <= w_byte;
      if (wr_trig) trig_cfg_r <= w_byte & acc_pkg::TC_WMASK;
      if (wr_ref) ref_cfg_r <= w_byte & acc_pkg::RC_WMASK;
      if (wr_upper) upper_limit_r <= w_byte;
      if (wr_lower) lower_limit_r <= w_byte;
      if (wr_mask) irq_mask_r <= w_byte[acc_pkg::IRQ_BITS-1:0];
    end
  end

  // a software write of the run bit outranks the one-shot self-clear
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      run_en_r <= 1'b0;
    end else if (sw_run_wr && w_lane0) begin
      run_en_r <= w_byte[acc_pkg::MC_RUN];
    end else if (conv_done && sw_mode && f_oneshot) begin
      run_en_r <= 1'b0;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_status_r <= '0;
      result_r     <= 12'h000;
      end_pulse_r  <= 1'b0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      end_pulse_r  <= conv_done && cmp_hit;
      if (conv_done) begin
        result_r <= res_val;
      end
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      comp_en_r <= 1'b0;
      conv_r    <= 1'b0;
      posref_r  <= 2'b00;
      negref_r  <= 1'b0;
      chan_r    <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      comp_en_r <= f_comp_en;
      conv_r    <= (state_nxt == acc_pkg::ACC_CONV);
      // prohibited code falls back to the supply, never a floating ref
      posref_r  <= (f_posref == acc_pkg::POSREF_BAD) ? 2'b00
                                                      : f_posref;
      negref_r  <= ref_cfg_r[acc_pkg::RC_NEG];
      chan_r    <= mode_ctrl_r[acc_pkg::MC_CHAN];
      irq_r     <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // ready flags held in flops: ready from the first clock edge after reset onward
  logic aw_rdy_r;
  logic w_rdy_r;
  logic ar_rdy_r;

  assign S_AXI_AWREADY_OUT      = 1'b0 | aw_rdy_r;
  assign S_AXI_WREADY_OUT       = 1'b0 | w_rdy_r;
  assign S_AXI_BVALID_OUT       = bvalid_r;
  assign S_AXI_BRESP_OUT        = bresp_r;
  assign S_AXI_ARREADY_OUT      = ar_rdy_r;
  assign S_AXI_RVALID_OUT       = rvalid_r;
  assign S_AXI_RDATA_OUT        = rdata_r;
  assign S_AXI_RRESP_OUT        = rresp_r;
  assign COMPARATOR_ENABLE_OUT  = comp_en_r;
  assign CONVERTING_OUT         = conv_r;
  assign POS_REF_SEL_OUT        = posref_r;
  assign NEG_REF_SEL_OUT        = negref_r;
  assign CHANNEL_MODE_OUT       = chan_r;
  assign CONVERSION_END_IRQ_OUT = end_pulse_r;
  assign IRQ_OUT                = irq_r;

  // readies rise one edge after reset and then stay up
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_rdy_r <= 1'b0;
      w_rdy_r  <= 1'b0;
      ar_rdy_r <= 1'b0;
    end else begin
      aw_rdy_r <= 1'b1;
      w_rdy_r  <= 1'b1;
      ar_rdy_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== hw/acc_pkg.sv ====
// constants, register map and types of the a/d conversion control block
package acc_pkg;
  // register indices; byte address is index times four
  localparam logic [19:0] IDX_MODE_CTRL   = 20'hfff30;
  localparam logic [19:0] IDX_TRIG_CFG    = 20'hfff32;
  localparam logic [19:0] IDX_REF_CMP_CFG = 20'hf0010;
  localparam logic [19:0] IDX_UPPER_LIMIT = 20'hf0011;
  localparam logic [19:0] IDX_LOWER_LIMIT = 20'hf0012;
  localparam logic [19:0] IDX_RESULT      = 20'hf0014;
  localparam logic [19:0] IDX_IRQ_STATUS  = 20'hf0015;
  localparam logic [19:0] IDX_IRQ_MASK    = 20'hf0016;
  localparam int          ADDR_W          = 22;

  // reset values
  localparam logic [7:0]  RST_MODE_CTRL   = 8'h00;
  localparam logic [7:0]  RST_TRIG_CFG    = 8'h00;
  localparam logic [7:0]  RST_REF_CMP_CFG = 8'h00;
  localparam logic [7:0]  RST_UPPER_LIMIT = 8'hff;
  localparam logic [7:0]  RST_LOWER_LIMIT = 8'h00;

  // mode control fields
  localparam int MC_RUN      = 7;
  localparam int MC_CHAN     = 6;
  localparam int MC_DIV_LSB  = 3;
  localparam int MC_VM_LSB   = 1;
  localparam int MC_CMP_EN   = 0;
  // trigger config fields
  localparam int TC_MODE_HI  = 7;
  localparam int TC_MODE_LO  = 6;
  localparam int TC_ONESHOT  = 5;
  localparam int TC_SRC_LSB  = 0;
  localparam logic [7:0] TC_WMASK = 8'he3;
  // reference / compare config fields
  localparam int RC_POS_LSB  = 6;
  localparam int RC_NEG      = 5;
  localparam int RC_SENSE    = 3;
  localparam int RC_LOW_POWER_WAKE_STATE   = 2;
  localparam int RC_RES      = 0;
  localparam logic [7:0] RC_WMASK = 8'hed;

  localparam logic [1:0] SRC_TIMER_CH1 = 2'b00;
  localparam logic [1:0] SRC_INTERVAL  = 2'b11;
  localparam logic [1:0] POSREF_BAD    = 2'b11;

  // conversion cycles at divide-by-32, one per voltage mode
  localparam int CONV_CYC_NORMAL1 = 1728;
  localparam int CONV_CYC_NORMAL2 = 2112;
  localparam int CONV_CYC_LOWV1   = 2432;
  localparam int CONV_CYC_LOWV2   = 7360;
  localparam int BASE_DIV         = 32;

  // stabilization wait before a wait-mode conversion
  localparam int CLK_MHZ          = 125;
  localparam int STAB_WAIT_NS     = 1000;
  localparam int STAB_CYC         = (STAB_WAIT_NS * CLK_MHZ + 999) / 1000;

  // interrupt status bits
  localparam int IRQ_CMP_END  = 0;
  localparam int IRQ_ANY_END  = 1;
  localparam int IRQ_BITS     = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {ACC_IDLE, ACC_STAB, ACC_CONV} acc_state_t;
endpackage

// ==== testbench/acc_conv_ctrl_monitor.sv ====
// port assertions for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl_monitor (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic [1:0]  S_AXI_RRESP_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  input wire logic        CONVERTING_OUT,
  input wire logic [1:0]  POS_REF_SEL_OUT,
  input wire logic        CONVERSION_END_IRQ_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  read_ans_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
    !S_AXI_RVALID_OUT |=> S_AXI_RVALID_OUT) else $error("read unanswered");
  b_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
    S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("b dropped");
  r_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("r dropped");
  r_lane_a: assert property (S_AXI_RVALID_OUT |->
    S_AXI_RDATA_OUT[31:12] == 20'h0) else $error("upper read bits set");
  err_zero_a: assert property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h2
    |-> S_AXI_RDATA_OUT == 32'h0) else $error("error read carries data");
  end_pulse_a: assert property (CONVERSION_END_IRQ_OUT |=>
    !CONVERSION_END_IRQ_OUT) else $error("end pulse too long");
  end_cause_a: assert property (CONVERSION_END_IRQ_OUT |->
    $past(CONVERTING_OUT)) else $error("end without conversion");
  posref_ok_a: assert property (POS_REF_SEL_OUT != 2'h3)
    else $error("reserved reference code driven");
endmodule
bind acc_conv_ctrl acc_conv_ctrl_monitor mon (.CORE_CLK_IN, .RST_N_IN,
  .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN,
  .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT,
  .S_AXI_RREADY_IN, .CONVERTING_OUT, .POS_REF_SEL_OUT,
  .CONVERSION_END_IRQ_OUT);
`default_nettype wire

// ==== testbench/acc_conv_ctrl_tb.sv ====
// self-checking bench for the a/d conversion control block
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl_tb;
  localparam logic [1:0] OK = acc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = acc_pkg::RESP_SLVERR;
  localparam logic [19:0] MC = acc_pkg::IDX_MODE_CTRL,
    TC = acc_pkg::IDX_TRIG_CFG, RC = acc_pkg::IDX_REF_CMP_CFG,
    UL = acc_pkg::IDX_UPPER_LIMIT, LL = acc_pkg::IDX_LOWER_LIMIT,
    RS = acc_pkg::IDX_RESULT, ST = acc_pkg::IDX_IRQ_STATUS,
    MK = acc_pkg::IDX_IRQ_MASK;
  localparam int RAT [4] = '{32, 16, 2, 1};
  localparam logic [2:0] DV [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  logic clk, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic tch = 0, iti = 0, lp = 0, hit;
  logic awr, wrd, bv, arr, rv, cmpe, cv, nsel, chm, cend, irq;
  logic [21:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, k;
  logic [1:0] bresp, rresp, psel;
  logic [11:0] ana = 0, s;
  logic [7:0] lo, up, h;
  int failures = 0, n_checks = 0, npl = 0, cl = 0, len = 0, p0, n;
  logic [33:0] bq[$], rq[$];
  // small counts keep every conversion within a few hundred cycles
  acc_conv_ctrl #(.CYC_NORMAL1(64), .CYC_NORMAL2(96), .CYC_LOWV1(128),
    .CYC_LOWV2(160)) dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
    .TIMER_CH1_IRQ_IN(tch), .INTERVAL_TIMER_IRQ_IN(iti),
    .LOW_POWER_WAKE_STATE_IN(lp), .ANALOG_SAMPLE_IN(ana),
    .COMPARATOR_ENABLE_OUT(cmpe), .CONVERTING_OUT(cv),
    .POS_REF_SEL_OUT(psel), .NEG_REF_SEL_OUT(nsel),
    .CHANNEL_MODE_OUT(chm), .CONVERSION_END_IRQ_OUT(cend), .IRQ_OUT(irq));
  task automatic chk(input logic [33:0] sv, input logic [33:0] ev);
    n_checks++;
    if (sv !== ev) begin
      failures++;
      $display("[ERR] t=%0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [19:0] i, input logic [7:0] d,
      input logic [1:0] r);
    awa <= {i, 2'b00};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bq.push_back({32'h0, r});
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (awv || wv);
    // ready held off one cycle after the answer rises so it must stand
    @(posedge clk);
    br <= 1;
    do @(posedge clk); while (!bv);
    br <= 0;
  endtask
  task automatic rd(input logic [19:0] i, input logic [11:0] d,
      input logic [1:0] r);
    ara <= {i, 2'b00};
    arv <= 1;
    rq.push_back({r, 20'h0, d});
    do @(posedge clk); while (!arr);
    arv <= 0;
    @(posedge clk);
    rr <= 1;
    do @(posedge clk); while (!rv);
    rr <= 0;
  endtask
  task automatic pulse(input logic t);
    tch <= !t;
    iti <= t;
    @(posedge clk);
    tch <= 0;
    iti <= 0;
  endtask
  always @(posedge clk) begin
    if (bv && br) chk({32'h0, bresp}, bq.pop_front());
    if (rv && rr) chk({rresp, rdat}, rq.pop_front());
    if (cend) npl++;
    if (cv) cl++;
    else if (cl != 0) begin
      len = cl;
      cl = 0;
    end
  end
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    void'($urandom(19213));
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(UL, 12'hff, OK);
    rd(LL, 12'h00, OK);
    rd(20'h00001, 12'h0, ER);
    wr(20'h00001, 8'h5a, ER);
    wr(UL, 8'h3c, OK);
    rd(UL, 12'h3c, OK);
    wr(LL, 8'hc3, OK);
    rd(LL, 12'hc3, OK);
    for (int p = 0; p < 4; p++) begin
      wr(RC, {p[1:0], p[0], 5'h0}, OK);
      chk({nsel, psel}, {p[0], (p == 3) ? 2'b00 : p[1:0]});
    end
    wr(MC, 8'h40, OK);
    chk({chm, cmpe}, 2'b10);
    wr(MC, 8'h01, OK);
    chk({chm, cmpe}, 2'b01);
    for (int i = 0; i < 16; i++) begin
      s = 12'($urandom);
      k = $urandom;
      lo = k[15:8];
      up = k[23:16];
      n = (2 + i % 4) * RAT[i / 4];
      ana <= s;
      wr(UL, up, OK);
      wr(LL, lo, OK);
      wr(RC, {4'h0, k[0], 2'b0, k[1]}, OK);
      wr(MK, {6'h0, k[2], 1'b0}, OK);
      wr(TC, {1'b0, k[3], 6'h20}, OK);
      p0 = npl;
      wr(MC, {2'b10, DV[i / 4], i[1:0], 1'b1}, OK);
      repeat (n + 8) @(posedge clk);
      h = s[11:4];
      hit = k[0] ? (h < lo || h > up) : (lo <= h && h <= up);
      chk(len, n);
      chk(npl - p0, hit);
      chk(irq, k[2]);
      rd(RS, k[1] ? {h, 4'h0} : s, OK);
      rd(MC, {2'b00, DV[i / 4], i[1:0], 1'b1}, OK);
      rd(ST, {1'b1, hit}, OK);
      wr(ST, 8'h03, OK);
      rd(ST, 12'h0, OK);
      chk(irq, 0);
    end
    wr(UL, 8'hff, OK);
    wr(LL, 8'h00, OK);
    for (int i = 0; i < 8; i++) begin
      lp <= i[2];
      wr(RC, {5'h0, i[1], 2'b0}, OK);
      wr(TC, {6'h28, i[1:0]}, OK);
      wr(MC, 8'hb9, OK);
      p0 = npl;
      pulse(0);
      repeat (12) @(posedge clk);
      chk(npl - p0, i % 4 == 0 && (!i[2] || i[1]));
      pulse(1);
      repeat (12) @(posedge clk);
      chk(npl - p0, i % 4 % 3 == 0 && (!i[2] || i[1]));
    end
    lp <= 0;
    wr(TC, 8'he3, OK);
    p0 = npl;
    pulse(1);
    repeat (acc_pkg::STAB_CYC - 10) @(posedge clk);
    chk(npl - p0, 0);
    chk(cv, 0);
    repeat (30) @(posedge clk);
    chk(npl - p0, 1);
    wr(TC, 8'h00, OK);
    p0 = npl;
    wr(MC, 8'hb9, OK);
    repeat (20) @(posedge clk);
    wr(MC, 8'h39, OK);
    chk(npl - p0 > 5, 1);
    finish_test();
  end
endmodule
`default_nettype wire
